// >>> logic/async_serial_transceiver.sv
/*
  Asynchronous serial transceiver: registers, transmitter, clocking
  and receive flag handling. Receive shifter and baud generator are
  instantiated. Assumes a single-cycle register port master.
*/
`timescale 1ns/10ps
`default_nettype none
`include "serial_unit_params.svh"
module async_serial_transceiver (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  // serial lines
  input  wire logic       rxLine,
  output logic            txLine,
  input  wire logic       serialClkIn,
  output logic            serialClkOut,
  output logic            serialClkOe,
  // interrupt requests
  output logic            txEmptyIrq,
  output logic            txDoneIrq,
  output logic            rxFullIrq,
  output logic            rxErrorIrq
);
  typedef enum logic [1:0] {
    T_IDLE  = 2'b00,
    T_START = 2'b01,
    T_DATA  = 2'b10,
    T_STOP  = 2'b11
  } tstate_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] baud;
    logic [7:0] ctl;
    logic [7:0] txBuf;
    logic [7:0] rxBuf;
    logic       txEmpty;
    logic       txDone;
    logic       rxFull;
    logic       ovr;
    logic       frm;
    logic       par;
    tstate_t    tfsm;
    logic [3:0] tsub;
    logic [3:0] tbit;
    logic [7:0] txShift;
    logic       tpar;
    logic       txLine;
    logic       sclk;
    logic       extPrev;
    logic       extTick;
    logic [7:0] rdData;
    logic       txEmptyIrq;
    logic       txDoneIrq;
    logic       rxFullIrq;
    logic       rxErrorIrq;
  } state_t;
  state_t st, next_st;

  // two-stage synchronisers for pins
  logic [1:0] rxSync;
  logic [1:0] ckSync;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxSync <= 2'b11;
      ckSync <= 2'b00;
    end else begin
      rxSync <= {rxSync[0], rxLine};
      ckSync <= {ckSync[0], serialClkIn};
    end
  end

  logic       intTick;
  logic       tick;
  logic       extClk;
  logic       rxDone;
  logic [7:0] lineStatus;
  logic [3:0] dataBits;
  logic       anyErr;
  serial_unit_pkg::frame_fmt_t fmt;
  serial_unit_pkg::rx_result_t rxRes;

  baud_tick_gen #(
    .CNT_W    (18)
  ) u_baud (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .prescale (st.mode[`MODE_PRE_LO +: 2]),
    .divisor  (st.baud),
    .tick     (intTick)
  );

  // receiver runs beside the transmitter with its own buffer
  serial_rx_core u_rx (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .tick     (tick),
    .enable   (st.ctl[`CTL_RXON] & ~anyErr),
    .fmt      (fmt),
    .line     (rxSync[1]),
    .done     (rxDone),
    .result   (rxRes)
  );

  always_comb begin
    fmt.sevenBit  = st.mode[`MODE_SEVEN];
    fmt.parityOn  = st.mode[`MODE_PAR_EN];
    fmt.parityOdd = st.mode[`MODE_PAR_ODD];
    fmt.twoStop   = st.mode[`MODE_TWO_STOP];
    // external 16x clock when select bit 1 set in async mode
    // synchronous mode is not served, so divisor zero needs no guard
    extClk = st.ctl[`CTL_CKSEL1] & ~st.mode[`MODE_SYNC];
    tick = extClk ? st.extTick : intTick;
    anyErr = st.ovr | st.frm | st.par;
    dataBits = fmt.sevenBit ? 4'h7 : 4'h8;
    lineStatus = 8'h00;
    lineStatus[`ST_TXE] = st.txEmpty;
    lineStatus[`ST_RXF] = st.rxFull;
    lineStatus[`ST_OVR] = st.ovr;
    lineStatus[`ST_FRM] = st.frm;
    lineStatus[`ST_PAR] = st.par;
    lineStatus[`ST_TXD] = st.txDone;
  end

  always_comb begin
    next_st = st;
    next_st.extPrev = ckSync[1];
    next_st.extTick = ckSync[1] & ~st.extPrev;
    next_st.txEmptyIrq = 1'b0;
    next_st.rxErrorIrq = 1'b0;
    next_st.rxFullIrq = 1'b0;

    // register reads: data valid the cycle after the strobe
    next_st.rdData = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        `ADDR_MODE:    next_st.rdData = st.mode;
        `ADDR_BAUD:    next_st.rdData = st.baud;
        `ADDR_CONTROL: next_st.rdData = st.ctl;
        `ADDR_TXBUF:   next_st.rdData = st.txBuf;
        `ADDR_STATUS:  next_st.rdData = lineStatus;
        `ADDR_RXBUF: begin
          next_st.rdData = st.rxBuf;
          next_st.rxFull = 1'b0;
        end
        default:       next_st.rdData = 8'h00;
      endcase
    end

    // register writes; status bits RXF, OVR, FRM and PAR clear by writing zero
    if (regWr) begin
      unique case (regAddr)
        `ADDR_MODE:    next_st.mode = regWrData;
        `ADDR_BAUD:    next_st.baud = regWrData;
        `ADDR_CONTROL: next_st.ctl = regWrData;
        `ADDR_TXBUF: begin
          next_st.txBuf = regWrData;
          next_st.txEmpty = 1'b0;
          next_st.txDone = 1'b0;
        end
        `ADDR_STATUS: begin
          if (!regWrData[`ST_RXF]) next_st.rxFull = 1'b0;
          if (!regWrData[`ST_OVR]) next_st.ovr = 1'b0;
          if (!regWrData[`ST_FRM]) next_st.frm = 1'b0;
          if (!regWrData[`ST_PAR]) next_st.par = 1'b0;
        end
        default: ;
      endcase
    end

    // rx_on off leaves flags and buffer untouched
    if (rxDone) begin
      if (st.rxFull) begin
        next_st.ovr = 1'b1;
        next_st.rxFull = 1'b1;
        next_st.rxErrorIrq = st.ctl[`CTL_RXIE];
      end else begin
        next_st.rxBuf = rxRes.data;
      end
      if (rxRes.parityErr) next_st.par = 1'b1;
      if (rxRes.frameErr) next_st.frm = 1'b1;
      if (!st.rxFull && (rxRes.parityErr || rxRes.frameErr)) begin
        next_st.rxFull = st.rxFull;
        next_st.rxErrorIrq = st.ctl[`CTL_RXIE];
      end else if (!st.rxFull) begin
        next_st.rxFull = 1'b1;
        next_st.rxFullIrq = st.ctl[`CTL_RXIE];
      end
    end

    // transmitter
    if (!next_st.ctl[`CTL_TXON]) begin
      next_st.txEmpty = 1'b1;
      next_st.tfsm = T_IDLE;
      next_st.txLine = 1'b1;
    end else if (tick) begin
      next_st.tsub = st.tsub + 4'h1;
      unique case (st.tfsm)
        T_IDLE: begin
          next_st.txLine = 1'b1;
          if (!st.txEmpty) begin
            next_st.txShift = st.txBuf;
            next_st.txEmpty = 1'b1;
            next_st.txEmptyIrq = st.ctl[`CTL_TXIE];
            next_st.tfsm = T_START;
            next_st.tsub = 4'h0;
            next_st.txLine = 1'b0;
          end
        end
        T_START: begin
          if (st.tsub == `LAST_TICK) begin
            next_st.tfsm = T_DATA;
            next_st.tbit = 4'h0;
            next_st.tpar = fmt.parityOdd;
            next_st.txLine = st.txShift[0];
          end
        end
        T_DATA: begin
          if (st.tsub == `LAST_TICK) begin
            next_st.tbit = st.tbit + 4'h1;
            if (st.tbit < dataBits) begin
              next_st.tpar = st.tpar ^ st.txShift[0];
              next_st.txShift = {1'b0, st.txShift[7:1]};
            end
            if (st.tbit + 4'h1 < dataBits) begin
              next_st.txLine = st.txShift[1];
            end else if (st.tbit + 4'h1 == dataBits && fmt.parityOn) begin
              next_st.txLine = st.tpar ^ st.txShift[0];
            end else begin
              next_st.tfsm = T_STOP;
              next_st.tbit = 4'h0;
              next_st.txLine = 1'b1;
              if (st.txEmpty) begin
                next_st.txDone = 1'b1;
              end
            end
          end
        end
        T_STOP: begin
          if (st.tsub == `LAST_TICK) begin
            if (fmt.twoStop && st.tbit == 4'h0) begin
              next_st.tbit = 4'h1;
            end else if (!st.txEmpty) begin
              next_st.txShift = st.txBuf;
              next_st.txEmpty = 1'b1;
              next_st.txEmptyIrq = st.ctl[`CTL_TXIE];
              next_st.txDone = 1'b0;
              next_st.tfsm = T_START;
              next_st.txLine = 1'b0;
            end else begin
              next_st.txDone = 1'b1;
              next_st.tfsm = T_IDLE;
            end
          end
        end
      endcase
    end
    // a write in this cycle still clears the flag just set
    if (regWr && regAddr == `ADDR_TXBUF && st.ctl[`CTL_TXON]) begin
      next_st.txEmpty = 1'b0;
    end
    next_st.txDoneIrq = st.ctl[`CTL_TDIE] & st.txDone;

    // bit-rate clock out, rising mid-bit
    next_st.sclk = (st.tsub >= 4'h8);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.baud <= `BAUD_RESET;
      st.mode <= `MODE_RESET;
      st.ctl <= `CTL_RESET;
      st.txEmpty <= 1'b1;
      st.txDone <= 1'b1;
      st.txLine <= 1'b1;
      st.extPrev <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign regRdData = st.rdData;
  assign txLine = st.txLine;
  assign serialClkOut = st.sclk;
  assign txEmptyIrq = st.txEmptyIrq;
  assign txDoneIrq = st.txDoneIrq;
  assign rxFullIrq = st.rxFullIrq;
  assign rxErrorIrq = st.rxErrorIrq;
  // output only with internal clock and select0 set
  always_comb begin
    serialClkOe = st.ctl[`CTL_CKSEL0] & ~st.ctl[`CTL_CKSEL1];
  end
endmodule
`default_nettype wire

// >>> logic/serial_unit_params.svh
/*
  Constants for the asynchronous serial unit: register map, field
  positions, reset values and baud generator figures.
  Assumes inclusion by the package and the modules by bare name.
*/
`ifndef SERIAL_UNIT_PARAMS_SVH
`define SERIAL_UNIT_PARAMS_SVH

// register offsets
`define ADDR_MODE     3'h0
`define ADDR_BAUD     3'h1
`define ADDR_CONTROL  3'h2
`define ADDR_TXBUF    3'h3
`define ADDR_STATUS   3'h4
`define ADDR_RXBUF    3'h5

// frame_mode_reg fields
`define MODE_SYNC     7
`define MODE_SEVEN    6
`define MODE_PAR_EN   5
`define MODE_PAR_ODD  4
`define MODE_TWO_STOP 3
`define MODE_PRE_LO   0
`define MODE_RESET    8'h00

// serial_control_reg fields
`define CTL_TXIE      7
`define CTL_RXIE      6
`define CTL_TXON      5
`define CTL_RXON      4
`define CTL_TDIE      2
`define CTL_CKSEL1    1
`define CTL_CKSEL0    0
`define CTL_RESET     8'h00

// line_status fields
`define ST_TXE        7
`define ST_RXF        6
`define ST_OVR        5
`define ST_FRM        4
`define ST_PAR        3
`define ST_TXD        2
`define ST_RESET      8'h84

`define BAUD_RESET    8'hFF
`define BASE_DIV      64
`define OVERSAMPLE    16
`define MID_TICK      4'h7
`define LAST_TICK     4'hF
`endif

// >>> logic/serial_unit_pkg.sv
/*
  Types shared by the serial unit modules.
  Assumes the constants header is on the include path.
*/
`include "serial_unit_params.svh"
package serial_unit_pkg;
  typedef struct packed {
    logic       sevenBit;
    logic       parityOn;
    logic       parityOdd;
    logic       twoStop;
  } frame_fmt_t;

  typedef struct packed {
    logic [7:0] data;
    logic       parityErr;
    logic       frameErr;
  } rx_result_t;
endpackage

// >>> logic/baud_tick_gen.sv
/*
  Baud generator: one tick per 1/16 bit (4*4^n*(N+1) clocks).
  Assumes a free running system clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "serial_unit_params.svh"
module baud_tick_gen #(
  parameter int CNT_W = 18
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // setting
  input  wire logic [1:0] prescale,
  input  wire logic [7:0] divisor,
  // output
  output logic            tick
);
  initial begin
    if (CNT_W < 18) $error("baud counter too narrow");
  end

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             tick;
  } state_t;
  state_t st, next_st;
  logic [CNT_W-1:0] limit;

  // 64*4^n*(N+1) per bit, /16 for oversample ticks
  always_comb begin
    limit = CNT_W'((`BASE_DIV / `OVERSAMPLE) * ({10'h0, divisor} + 18'h1)
            << (2 * prescale)) - CNT_W'(1);
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count >= limit) begin
      next_st.count = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tick = st.tick;
endmodule
`default_nettype wire

// >>> logic/serial_rx_core.sv
/*
  Receive shifter: 16x oversampled start detection and framing.
  Assumes line is already synchronised; tick is a one-cycle strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "serial_unit_params.svh"
module serial_rx_core (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  // control
  input  wire logic                       tick,
  input  wire logic                       enable,
  input  wire serial_unit_pkg::frame_fmt_t fmt,
  input  wire logic                       line,
  // result
  output logic                            done,
  output serial_unit_pkg::rx_result_t     result
);
  typedef enum logic [1:0] {
    IDLE  = 2'b00,
    START = 2'b01,
    DATA  = 2'b10,
    STOP  = 2'b11
  } rstate_t;
  typedef struct packed {
    rstate_t    fsm;
    logic [3:0] sub;
    logic [3:0] bitNo;
    logic [7:0] shift;
    logic       par;
    logic       done;
    serial_unit_pkg::rx_result_t res;
  } state_t;
  state_t st, next_st;
  logic [3:0] dataBits;

  always_comb begin
    dataBits = fmt.sevenBit ? 4'h7 : 4'h8;
    next_st = st;
    next_st.done = 1'b0;
    if (!enable) begin
      next_st.fsm = IDLE;
    end else if (tick) begin
      next_st.sub = st.sub + 4'h1;
      unique case (st.fsm)
        IDLE: begin
          if (!line) begin
            next_st.fsm = START;
            next_st.sub = 4'h0;
          end
        end
        START: begin
          if (st.sub == `MID_TICK) begin
            // glitch shorter than half a bit is ignored
            next_st.fsm = line ? IDLE : DATA;
            next_st.sub = 4'h0;
            next_st.bitNo = 4'h0;
            next_st.par = fmt.parityOdd;
          end
        end
        DATA: begin
          if (st.sub == `LAST_TICK) begin
            next_st.bitNo = st.bitNo + 4'h1;
            if (st.bitNo < dataBits) begin
              next_st.shift = {line, st.shift[7:1]};
            end
            next_st.par = st.par ^ line;
            if (st.bitNo == dataBits - 4'h1 + {3'h0, fmt.parityOn}) begin
              next_st.fsm = STOP;
            end
          end
        end
        STOP: begin
          if (st.sub == `LAST_TICK) begin
            next_st.fsm = IDLE;
            next_st.done = 1'b1;
            next_st.res.data = fmt.sevenBit ? {1'b0, st.shift[7:1]}
                                            : st.shift;
            next_st.res.parityErr = fmt.parityOn & st.par;
            next_st.res.frameErr = ~line;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign done = st.done;
  assign result = st.res;
endmodule
`default_nettype wire

// >>> tb/serial_unit_chk.sv
/*
  Port-level checker for the serial transceiver.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
`include "serial_unit_params.svh"
module serial_unit_chk (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  // serial lines
  input wire logic       rxLine,
  input wire logic       txLine,
  input wire logic       serialClkIn,
  input wire logic       serialClkOut,
  input wire logic       serialClkOe,
  // interrupt requests
  input wire logic       txEmptyIrq,
  input wire logic       txDoneIrq,
  input wire logic       rxFullIrq,
  input wire logic       rxErrorIrq
);
  // copy of the control register as software last wrote it
  logic [7:0] ctlShadow;
  always_ff @(posedge clk_sys) begin
    if (reset)
      ctlShadow <= `CTL_RESET;
    else if (regWr && regAddr == `ADDR_CONTROL)
      ctlShadow <= regWrData;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  idle_high_a: assert property ($fell(reset) |-> txLine)
    else $error("line not idle after reset");
  start_len_a: assert property ($fell(txLine) |-> !txLine [*8])
    else $error("start bit too short");
  bit_hold_a: assert property ($changed(txLine) |=> $stable(txLine) [*8])
    else $error("tx bit too short");
  clk_oe_a: assert property (serialClkOe == (ctlShadow[`CTL_CKSEL0] && !ctlShadow[`CTL_CKSEL1]))
    else $error("clock output enable wrong");
  // a low line means a frame is running, so the rise must sit mid-bit
  mid_bit_a: assert property ($rose(serialClkOut) && serialClkOe && !txLine |-> ($past(txLine, 16) == txLine) ##1 $stable(txLine) [*8])
    else $error("clock rise not mid-bit");
  txe_en_a: assert property (txEmptyIrq |-> ctlShadow[`CTL_TXIE])
    else $error("tx empty irq while disabled");
  txe_pulse_a: assert property (txEmptyIrq |=> !txEmptyIrq)
    else $error("tx empty irq not a pulse");
  done_en_a: assert property (txDoneIrq |-> ctlShadow[`CTL_TDIE])
    else $error("tx done irq while disabled");
  rxf_en_a: assert property (rxFullIrq |-> ctlShadow[`CTL_RXIE])
    else $error("rx full irq while disabled");
  err_en_a: assert property (rxErrorIrq |-> ctlShadow[`CTL_RXIE])
    else $error("error irq while disabled");
  irq_excl_a: assert property (!(rxFullIrq && rxErrorIrq))
    else $error("full and error irq together");

  cover property (txEmptyIrq);
  cover property ($rose(rxErrorIrq));
  cover property ($rose(serialClkOut) && serialClkOe);
endmodule
`default_nettype wire

// >>> tb/serial_peer.sv
/*
  Remote asynchronous station: sends frames on rxLine and captures
  frames from txLine. Assumes BIT system clocks per bit.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_peer #(
  parameter int BIT = 64
) (
  // clock
  input  wire logic clk_sys,
  // serial lines
  input  wire logic txLine,
  output logic      rxLine
);
  logic [15:0] q[$];
  time         tq[$];
  int          rxBits = 10;
  logic [15:0] w;
  int          k;

  initial rxLine = 1'b1;

  // start low, data lsb first, optional parity, stop, then idle high
  task automatic send(input logic [7:0] d, input logic par,
                      input logic pv, input logic sv);
    logic [11:0] f;
    int          i;
    f = par ? {1'b1, sv, pv, d, 1'b0} : {2'b11, sv, d, 1'b0};
    for (i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      rxLine <= f[i];
      repeat (BIT - 1) @(posedge clk_sys);
    end
  endtask

  // no wait after the last sample, so a back-to-back start is caught
  initial begin
    forever begin
      @(negedge txLine);
      repeat (BIT / 2) @(posedge clk_sys);
      w = 16'h0000;
      for (k = 0; k < rxBits; k++) begin
        if (k > 0)
          repeat (BIT) @(posedge clk_sys);
        w[k] = txLine;
      end
      q.push_back(w);
      tq.push_back($time);
    end
  end
endmodule
`default_nettype wire

// >>> tb/async_serial_transceiver_tb.sv
/*
  Self-checking bench for the serial transceiver.
  Assumes baud divisor 0 and prescale 0, so 64 clocks per bit.
*/
`timescale 1ns/10ps
`default_nettype none
`include "serial_unit_params.svh"
module async_serial_transceiver_tb;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic [7:0] regRdData, rv;
  logic       rxLine, txLine, serialClkOut, serialClkOe;
  logic       txEmptyIrq, txDoneIrq, rxFullIrq, rxErrorIrq;
  logic [1:0] extDiv = 2'h0;
  wire logic  serialClkIn = extDiv[1];
  int         errors = 0;
  int         n_compared = 0;

  initial forever #4 clk_sys = ~clk_sys;
  // external 16x clock runs from time zero, initialization included
  always @(posedge clk_sys) extDiv <= extDiv + 2'h1;

  async_serial_transceiver u_dut (
    .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .rxLine(rxLine), .txLine(txLine),
    .serialClkIn(serialClkIn), .serialClkOut(serialClkOut),
    .serialClkOe(serialClkOe), .txEmptyIrq(txEmptyIrq),
    .txDoneIrq(txDoneIrq), .rxFullIrq(rxFullIrq),
    .rxErrorIrq(rxErrorIrq));
  serial_peer u_peer (.clk_sys(clk_sys), .txLine(txLine), .rxLine(rxLine));

  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic st_is(input logic [7:0] m, input logic [7:0] e);
    rd(`ADDR_STATUS, rv);
    chk({8'h00, rv & m}, {8'h00, e}, "status");
  endtask

  task automatic rx_is(input logic [7:0] e);
    rd(`ADDR_RXBUF, rv);
    chk({8'h00, rv}, {8'h00, e}, "rx data");
  endtask

  task automatic wait_st(input int b);
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(`ADDR_STATUS, rv);
      if (rv[b] === 1'b1)
        break;
    end
    chk({15'h0000, rv[b]}, 16'h0001, "status wait");
  endtask

  task automatic wait_q(input int n);
    int i;
    for (i = 0; i < 3000 && u_peer.q.size() < n; i++)
      @(posedge clk_sys);
    chk(16'(u_peer.q.size()), 16'(n), "frame count");
  endtask

  task automatic flush();
    repeat (64) @(posedge clk_sys);
    u_peer.q.delete();
    u_peer.tq.delete();
  endtask

  function automatic logic [15:0] fr8(input logic [7:0] d);
    return {6'h00, 1'b1, d, 1'b0};
  endfunction

  task automatic t_reset();
    st_is(8'hFF, 8'h84);
    wr(3'h7, 8'h5A);
    rd(3'h7, rv);
    chk({8'h00, rv}, 16'h0000, "unmapped");
    wr(`ADDR_BAUD, 8'h00);
    wr(`ADDR_MODE, 8'h00);
    wr(`ADDR_CONTROL, 8'hF4);
  endtask

  task automatic t_tx_b2b();
    wr(`ADDR_TXBUF, 8'hA5);
    wait_st(`ST_TXE);
    wr(`ADDR_TXBUF, 8'h3C);
    st_is(8'h80, 8'h00);
    wait_q(2);
    chk(u_peer.q[0], fr8(8'hA5), "frame 1");
    chk(u_peer.q[1], fr8(8'h3C), "frame 2");
    chk(16'((u_peer.tq[1] - u_peer.tq[0]) / 8), 16'h0280, "gap");
    repeat (40) @(posedge clk_sys);
    st_is(8'h84, 8'h84);
    chk({15'h0000, txDoneIrq}, 16'h0001, "done irq");
    flush();
  endtask

  task automatic t_rx();
    u_peer.send(8'h96, 1'b0, 1'b0, 1'b1);
    wait_st(`ST_RXF);
    rx_is(8'h96);
    st_is(8'h40, 8'h00);
    u_peer.send(8'h11, 1'b0, 1'b0, 1'b1);
    wait_st(`ST_RXF);
    u_peer.send(8'h22, 1'b0, 1'b0, 1'b1);
    wait_st(`ST_OVR);
    st_is(8'h78, 8'h60);
    rx_is(8'h11);
    u_peer.send(8'h33, 1'b0, 1'b0, 1'b1);
    repeat (100) @(posedge clk_sys);
    rx_is(8'h11);
    wr(`ADDR_STATUS, 8'h00);
    u_peer.send(8'h44, 1'b0, 1'b0, 1'b1);
    wait_st(`ST_RXF);
    rx_is(8'h44);
    u_peer.send(8'h5A, 1'b0, 1'b0, 1'b0);
    wait_st(`ST_FRM);
    st_is(8'h58, 8'h10);
    rx_is(8'h5A);
    wr(`ADDR_STATUS, 8'h00);
  endtask

  task automatic t_parity();
    wr(`ADDR_MODE, 8'h20);
    u_peer.send(8'h5B, 1'b1, ~^8'h5B, 1'b1);
    wait_st(`ST_PAR);
    st_is(8'h48, 8'h08);
    rx_is(8'h5B);
    wr(`ADDR_STATUS, 8'h00);
    wr(`ADDR_MODE, 8'h30);
    u_peer.rxBits = 11;
    wr(`ADDR_TXBUF, 8'hC3);
    wait_q(1);
    chk(u_peer.q[0], {5'h00, 1'b1, ~^8'hC3, 8'hC3, 1'b0}, "odd");
    flush();
    u_peer.rxBits = 10;
    wr(`ADDR_MODE, 8'h00);
  endtask

  task automatic t_disable();
    u_peer.send(8'h77, 1'b0, 1'b0, 1'b1);
    wait_st(`ST_RXF);
    wr(`ADDR_CONTROL, 8'hE4);
    st_is(8'h78, 8'h40);
    rx_is(8'h77);
    wr(`ADDR_CONTROL, 8'hF4);
    // all-ones data keeps the line high when the frame is cut off
    wr(`ADDR_TXBUF, 8'hFF);
    wait_st(`ST_TXE);
    wr(`ADDR_TXBUF, 8'h22);
    repeat (100) @(posedge clk_sys);
    // last step of a break: the pin is handed to the port first
    wr(`ADDR_CONTROL, 8'hD4);
    st_is(8'h80, 8'h80);
    wr(`ADDR_CONTROL, 8'hF4);
    repeat (1500) @(posedge clk_sys);
    flush();
  endtask

  task automatic t_clk();
    wr(`ADDR_CONTROL, 8'hF6);
    wr(`ADDR_TXBUF, 8'h69);
    wait_q(1);
    chk(u_peer.q[0], fr8(8'h69), "ext clock");
    flush();
    wr(`ADDR_CONTROL, 8'hF5);
    // control register takes the write at this edge; look once it settles
    #1;
    chk({15'h0000, serialClkOe}, 16'h0001, "clock oe");
    wr(`ADDR_TXBUF, 8'h0F);
    wait_q(1);
    chk(u_peer.q[0], fr8(8'h0F), "clock out");
    flush();
    wr(`ADDR_CONTROL, 8'hF4);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_tx_b2b();
    t_rx();
    t_parity();
    t_disable();
    t_clk();
    tally_and_finish();
  end

  initial begin
    #(8 * 80000);
    errors++;
    $display("[ERR] %0t watchdog", $time);
    tally_and_finish();
  end
endmodule

bind async_serial_transceiver serial_unit_chk u_chk (
  .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .rxLine(rxLine), .txLine(txLine),
  .serialClkIn(serialClkIn), .serialClkOut(serialClkOut),
  .serialClkOe(serialClkOe), .txEmptyIrq(txEmptyIrq),
  .txDoneIrq(txDoneIrq), .rxFullIrq(rxFullIrq),
  .rxErrorIrq(rxErrorIrq));
`default_nettype wire
